// ===== hw/link_pkg.sv
/*
  Constants of the five-wire handshake link on the device side:
  byte shape, handshake pulse width, acknowledge value and reply timeout.
  Assumes a 40 MHz system clock.
*/
// Summary of operation
// - Direction low device-to-host, high host-to-device.
// - Handshake pulse low for four CPU clocks.
// - Pulse while wake active means clear-to-send.
// - Pulse while wake inactive means request-to-send.
// - Device times out host replies, repeats handshake.
// - Direction returns high after device packet ends.
// - On collision device receives first, then re-requests.
// - Host drives clock and data-in; device drives data-out.
package link_pkg;

  localparam int          BYTE_BITS       = 8;
  localparam int          PULSE_CYCLES    = 4;
  localparam logic [7:0]  ACK_BYTE        = 8'h88;
  localparam logic [7:0]  IDLE_FILL       = 8'hff;
  localparam int          SYS_PERIOD_NS   = 25;
  localparam int          REPLY_TIMEOUT_US = 5000;
  localparam int          REPLY_TIMEOUT_CYCLES =
    (REPLY_TIMEOUT_US * 1000) / SYS_PERIOD_NS;
  localparam logic [2:0]  PULSE_LAST      = 3'(PULSE_CYCLES - 1);
  localparam logic [2:0]  BIT_LAST        = 3'(BYTE_BITS - 1);

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_RTS      = 3'h1,
    ST_WAIT_ACK = 3'h3,
    ST_SEND     = 3'h2,
    ST_CTS      = 3'h6,
    ST_HOST_RX  = 3'h7
  } link_state_t;

endpackage : link_pkg

// ===== hw/byte_shifter.sv
/*
  Clock-slave byte shifter: samples the host serial clock and data,
  finds clock edges and moves one byte in and one byte out.
  Assumes the system clock is many times faster than the serial clock.
*/
`timescale 1ns/100ps
module byte_shifter #(
  parameter bit CPOL      = 1'b0,
  parameter bit CPHA      = 1'b0,
  parameter bit LSB_FIRST = 1'b0
) (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       sclk_in,
  input  wire logic       sdi_in,
  input  wire logic       enable_in,
  input  wire logic       clear_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            load_out,
  output logic            sdo_out,
  output logic [7:0]      rx_byte_out,
  output logic            rx_valid_out
);

  logic [1:0] sclk_sync;
  logic [1:0] sdi_sync;
  logic       sclk_prev;
  logic [7:0] tx_reg;
  logic [7:0] rx_shift;
  logic [2:0] bit_cnt;
  logic       loaded;

  // ---------------------------------------------------------------
  // Edge decode
  // ---------------------------------------------------------------
  wire rise        = sclk_sync[1] & ~sclk_prev;
  wire fall        = ~sclk_sync[1] & sclk_prev;
  wire leading     = CPOL ? fall : rise;
  wire trailing    = CPOL ? rise : fall;
  wire sample_edge = CPHA ? trailing : leading;
  wire shift_edge  = CPHA ? leading : trailing;
  wire active      = enable_in & ~clear_in;
  wire [2:0] idx   = LSB_FIRST ? bit_cnt : 3'(link_pkg::BIT_LAST - bit_cnt);
  wire [7:0] next_rx = LSB_FIRST ? {sdi_sync[1], rx_shift[7:1]}
                                 : {rx_shift[6:0], sdi_sync[1]};
  wire byte_done   = active & loaded & sample_edge
                     & (bit_cnt == link_pkg::BIT_LAST);

  assign load_out = active & ~loaded;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sclk_sync <= {2{CPOL}};
      sdi_sync  <= 2'h0;
      sclk_prev <= CPOL;
    end else begin
      sclk_sync <= {sclk_sync[0], sclk_in};
      sdi_sync  <= {sdi_sync[0], sdi_in};
      sclk_prev <= sclk_sync[1];
    end
  end

  // ---------------------------------------------------------------
  // Byte shifting
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_reg  <= link_pkg::IDLE_FILL;
      loaded  <= 1'b0;
      bit_cnt <= 3'h0;
    end else if (!active) begin
      loaded  <= 1'b0;
      bit_cnt <= 3'h0;
    end else if (!loaded) begin
      tx_reg <= tx_byte_in;
      loaded <= 1'b1;
    end else if (sample_edge) begin
      bit_cnt <= bit_cnt + 3'h1;
      loaded  <= ~byte_done;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_shift <= 8'h00;
    end else if (active && loaded && sample_edge) begin
      rx_shift <= next_rx;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sdo_out <= 1'b1;
    end else if (!active) begin
      sdo_out <= 1'b1;
    end else if (!CPHA || shift_edge) begin
      sdo_out <= tx_reg[idx];
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_byte_out  <= 8'h00;
      rx_valid_out <= 1'b0;
    end else begin
      rx_valid_out <= byte_done;
      if (byte_done) begin
        rx_byte_out <= next_rx;
      end
    end
  end

endmodule : byte_shifter

// ===== hw/handshake_link.sv
/*
  Device end of the five-wire half-duplex handshake link: drives the
  direction line, answers wake requests, requests its own sends and
  passes packet bytes to and from local logic.
  Assumes the host clocks the serial link and follows the handshake.
*/
`timescale 1ns/100ps
module handshake_link #(
  parameter bit CPOL           = 1'b0,
  parameter bit CPHA           = 1'b0,
  parameter bit LSB_FIRST      = 1'b0,
  parameter int TIMEOUT_CYCLES = link_pkg::REPLY_TIMEOUT_CYCLES
) (
  input  wire logic       CLK_SYS_IN,
  input  wire logic       RESET_N_IN,
  input  wire logic       HOST_SERIAL_CLOCK_IN,
  input  wire logic       DEVICE_SERIAL_IN_IN,
  input  wire logic       WAKE_REQUEST_N_IN,
  output logic            DEVICE_SERIAL_OUT_OUT,
  output logic            DIRECTION_HANDSHAKE_OUT,
  input  wire logic [7:0] TX_BYTE_IN,
  input  wire logic       TX_VALID_IN,
  input  wire logic       TX_LAST_IN,
  output logic            TX_READY_OUT,
  output logic [7:0]      RX_BYTE_OUT,
  output logic            RX_VALID_OUT,
  input  wire logic       RX_END_IN,
  output logic            ACK_ERROR_OUT,
  output logic            TIMEOUT_OUT
);

  link_pkg::link_state_t state;
  link_pkg::link_state_t next_state;

  logic [1:0]  wake_sync;
  logic [2:0]  pulse_cnt;
  logic [31:0] wait_cnt;
  logic        last_loaded;
  logic        host_byte_seen;
  logic        dir;
  logic        ack_error;
  logic        timeout_flag;
  logic        load;
  logic [7:0]  shift_rx;
  logic        shift_rx_valid;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  wire wake_active = ~wake_sync[1];
  wire pulse_done  = (pulse_cnt == link_pkg::PULSE_LAST);
  wire timed_out   = (wait_cnt == 32'(TIMEOUT_CYCLES - 1));
  wire in_pulse    = (state == link_pkg::ST_RTS)
                   | (state == link_pkg::ST_CTS);
  wire ack_ok      = shift_rx_valid & (shift_rx == link_pkg::ACK_BYTE);
  wire ack_bad     = shift_rx_valid & (shift_rx != link_pkg::ACK_BYTE);
  wire in_send     = (state == link_pkg::ST_SEND);
  wire shift_on    = in_send
                   | (state == link_pkg::ST_WAIT_ACK)
                   | (state == link_pkg::ST_HOST_RX);
  wire shift_clear = (state == link_pkg::ST_WAIT_ACK) & ack_ok;
  wire send_end    = in_send & shift_rx_valid & last_loaded;
  wire waiting     = (state == link_pkg::ST_WAIT_ACK)
                   | ((state == link_pkg::ST_HOST_RX) & ~host_byte_seen
                      & wake_active);
  wire [7:0] tx_byte = in_send ? TX_BYTE_IN : link_pkg::IDLE_FILL;

  // No byte is taken once the last one of the packet is loaded
  assign TX_READY_OUT            = in_send & load & ~last_loaded;
  assign DIRECTION_HANDSHAKE_OUT = dir;
  assign ACK_ERROR_OUT           = ack_error;
  assign TIMEOUT_OUT             = timeout_flag;

  byte_shifter #(
    .CPOL      (CPOL),
    .CPHA      (CPHA),
    .LSB_FIRST (LSB_FIRST)
  ) u_shifter (
    .clk_in       (CLK_SYS_IN),
    .reset_n_in   (RESET_N_IN),
    .sclk_in      (HOST_SERIAL_CLOCK_IN),
    .sdi_in       (DEVICE_SERIAL_IN_IN),
    .enable_in    (shift_on),
    .clear_in     (shift_clear),
    .tx_byte_in   (tx_byte),
    .load_out     (load),
    .sdo_out      (DEVICE_SERIAL_OUT_OUT),
    .rx_byte_out  (shift_rx),
    .rx_valid_out (shift_rx_valid)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      link_pkg::ST_IDLE: begin
        if (wake_active) begin
          next_state = link_pkg::ST_CTS;
        end else if (TX_VALID_IN) begin
          next_state = link_pkg::ST_RTS;
        end
      end
      link_pkg::ST_CTS: begin
        if (pulse_done) begin
          next_state = link_pkg::ST_HOST_RX;
        end
      end
      link_pkg::ST_RTS: begin
        if (pulse_done) begin
          next_state = link_pkg::ST_WAIT_ACK;
        end
      end
      link_pkg::ST_WAIT_ACK: begin
        if (wake_active) begin
          next_state = link_pkg::ST_CTS;
        end else if (ack_ok) begin
          next_state = link_pkg::ST_SEND;
        end else if (ack_bad || timed_out) begin
          next_state = link_pkg::ST_RTS;
        end
      end
      link_pkg::ST_HOST_RX: begin
        if (RX_END_IN) begin
          next_state = link_pkg::ST_IDLE;
        end else if (timed_out) begin
          next_state = link_pkg::ST_CTS;
        end
      end
      link_pkg::ST_SEND: begin
        if (send_end) begin
          next_state = link_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = link_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state     <= link_pkg::ST_IDLE;
      wake_sync <= 2'h3;
    end else begin
      state     <= next_state;
      wake_sync <= {wake_sync[0], WAKE_REQUEST_N_IN};
    end
  end

  // ---------------------------------------------------------------
  // Direction line and pulse width
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pulse_cnt <= 3'h0;
    end else if (in_pulse && !pulse_done) begin
      pulse_cnt <= pulse_cnt + 3'h1;
    end else begin
      pulse_cnt <= 3'h0;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      dir <= 1'b1;
    end else begin
      dir <= ~((next_state == link_pkg::ST_RTS)
             | (next_state == link_pkg::ST_CTS)
             | (next_state == link_pkg::ST_SEND));
    end
  end

  // ---------------------------------------------------------------
  // Reply timeout
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wait_cnt <= 32'h0;
    end else if (!waiting || next_state != state) begin
      wait_cnt <= 32'h0;
    end else begin
      wait_cnt <= wait_cnt + 32'h1;
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      timeout_flag <= 1'b0;
      ack_error    <= 1'b0;
    end else begin
      timeout_flag <= waiting & timed_out;
      ack_error    <= (state == link_pkg::ST_WAIT_ACK) & ack_bad
                      & ~wake_active;
    end
  end

  // ---------------------------------------------------------------
  // Packet tracking
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      last_loaded    <= 1'b0;
      host_byte_seen <= 1'b0;
    end else begin
      if (!in_send) begin
        last_loaded <= 1'b0;
      end else if (load && !last_loaded) begin
        last_loaded <= TX_LAST_IN;
      end
      if (state != link_pkg::ST_HOST_RX) begin
        host_byte_seen <= 1'b0;
      end else if (shift_rx_valid) begin
        host_byte_seen <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      RX_BYTE_OUT  <= 8'h00;
      RX_VALID_OUT <= 1'b0;
    end else begin
      RX_VALID_OUT <= (state == link_pkg::ST_HOST_RX) & shift_rx_valid;
      if (shift_rx_valid) begin
        RX_BYTE_OUT <= shift_rx;
      end
    end
  end

endmodule : handshake_link

// ===== dv/handshake_link_chk.sv
/*
  Port checker of the device link end.
  Assumes it is bound to handshake_link and sees only its ports.
*/
`timescale 1ns/100ps
module handshake_link_chk (
  input wire logic CLK_SYS_IN,
  input wire logic RESET_N_IN,
  input wire logic WAKE_REQUEST_N_IN,
  input wire logic DIRECTION_HANDSHAKE_OUT,
  input wire logic TX_VALID_IN,
  input wire logic TX_READY_OUT,
  input wire logic RX_VALID_OUT,
  input wire logic ACK_ERROR_OUT,
  input wire logic TIMEOUT_OUT
);
  wire d = DIRECTION_HANDSHAKE_OUT;
  wire w = WAKE_REQUEST_N_IN;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RESET_N_IN);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_low_min_four: assert property (
    $fell(d) |-> !d[*4]) else $error("direction low too short");
  a_cts_exact: assert property (
    $fell(d) && !w |-> !d[*4] ##1 d) else $error("bad grant pulse");
  a_rts_needs_tx: assert property (
    $fell(d) && w |-> TX_VALID_IN) else $error("request with no data");
  a_rx_dir_high: assert property (
    RX_VALID_OUT |-> d) else $error("host byte with direction low");
  a_ready_dir_low: assert property (
    TX_READY_OUT |-> !d || $past(!d)) else $error("load outside send");
  a_err_retry: assert property (
    ACK_ERROR_OUT |-> ##[1:8] !d) else $error("no retry after bad ack");
  a_tmo_retry: assert property (
    TIMEOUT_OUT |-> ##[1:8] !d) else $error("no retry after timeout");
  a_err_single: assert property (
    ACK_ERROR_OUT |=> !ACK_ERROR_OUT) else $error("long error pulse");
  a_tmo_single: assert property (
    TIMEOUT_OUT |=> !TIMEOUT_OUT) else $error("long timeout pulse");
  a_rx_single: assert property (
    RX_VALID_OUT |=> !RX_VALID_OUT) else $error("long byte strobe");
  c_grant: cover property ($fell(d) && !w);
  c_err: cover property (ACK_ERROR_OUT);
  c_tmo: cover property (TIMEOUT_OUT);
endmodule : handshake_link_chk

bind handshake_link handshake_link_chk chk (
  .CLK_SYS_IN              (CLK_SYS_IN),
  .RESET_N_IN              (RESET_N_IN),
  .WAKE_REQUEST_N_IN       (WAKE_REQUEST_N_IN),
  .DIRECTION_HANDSHAKE_OUT (DIRECTION_HANDSHAKE_OUT),
  .TX_VALID_IN             (TX_VALID_IN),
  .TX_READY_OUT            (TX_READY_OUT),
  .RX_VALID_OUT            (RX_VALID_OUT),
  .ACK_ERROR_OUT           (ACK_ERROR_OUT),
  .TIMEOUT_OUT             (TIMEOUT_OUT)
);

// ===== dv/host_model.sv
/*
  Host side model: serial clock master, mode 0, MSB first.
  Assumes the bench calls its tasks one at a time.
*/
`timescale 1ns/100ps
module host_model (
  input  wire logic dir_in,
  input  wire logic sdo_in,
  output logic      sclk_out,
  output logic      sdi_out,
  output logic      wake_n_out
);
  initial begin
    sclk_out = 1'b0;
    sdi_out = 1'b1;
    wake_n_out = 1'b1;
  end
  // Clock stands low outside frames; data inverted once released
  task automatic xfer(input logic [7:0] o, output logic [7:0] i);
    for (int k = 7; k >= 0; k--) begin
      sdi_out = o[k];
      #100 sclk_out = 1'b1;
      i[k] = sdo_in;
      #100 sclk_out = 1'b0;
    end
    sdi_out = ~sdi_out;
  endtask : xfer
  task automatic wake(input logic v);
    wake_n_out = ~v;
  endtask : wake
endmodule : host_model

// ===== dv/test_handshake_link.sv
/*
  Bench of the device link end with expected bytes kept in queues.
  Assumes design, checker and host model are compiled first.
*/
`timescale 1ns/100ps
module test_handshake_link;
  localparam int TMO = 200;
  logic clk = 1'b0, rst_n = 1'b0, tx_valid = 1'b0, rx_end = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic tx_last = 1'b0;
  wire logic sclk, sdi, wake_n, sdo, dir, tx_ready, rx_valid, ack_err, tmo;
  wire logic [7:0] rx_byte;
  logic [7:0] txq[$], rxq[$];
  logic [31:0] seed = 32'h33596f5e;
  int bad_count = 0, checks_done = 0, ti = 0, w, errs = 0, tmos = 0;
  host_model hm (.dir_in(dir), .sdo_in(sdo), .sclk_out(sclk),
    .sdi_out(sdi), .wake_n_out(wake_n));
  handshake_link #(.TIMEOUT_CYCLES(TMO)) dut (.CLK_SYS_IN(clk),
    .RESET_N_IN(rst_n), .HOST_SERIAL_CLOCK_IN(sclk),
    .DEVICE_SERIAL_IN_IN(sdi), .WAKE_REQUEST_N_IN(wake_n),
    .DEVICE_SERIAL_OUT_OUT(sdo), .DIRECTION_HANDSHAKE_OUT(dir),
    .TX_BYTE_IN(tx_byte), .TX_VALID_IN(tx_valid), .TX_LAST_IN(tx_last),
    .TX_READY_OUT(tx_ready), .RX_BYTE_OUT(rx_byte),
    .RX_VALID_OUT(rx_valid), .RX_END_IN(rx_end),
    .ACK_ERROR_OUT(ack_err), .TIMEOUT_OUT(tmo));
  initial forever #12.5 clk = ~clk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp8
  task automatic cmpn(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : cmpn
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_lvl(input logic v, input int lim);
    for (int n = 0; dir !== v; n++) begin
      if (n > lim) begin
        bad_count++;
        summarize();
      end
      tick();
    end
  endtask : wait_lvl
  task automatic pulse();
    wait_lvl(1'b0, 2000);
    for (w = 0; dir === 1'b0 && w < 50; w++) tick();
    cmpn(w, 4);
  endtask : pulse
  task automatic load(input int n);
    txq.delete();
    for (int k = 0; k < n; k++) txq.push_back(8'(rnd()));
    ti = 0;
    tx_byte = txq[0];
    tx_last = n == 1;
    tx_valid = 1'b1;
  endtask : load
  task automatic rts(input logic [7:0] ack);
    logic [7:0] r;
    pulse();
    hm.xfer(ack, r);
  endtask : rts
  task automatic dev_rx();
    logic [7:0] r;
    wait_lvl(1'b0, 200);
    for (int k = 0; k < txq.size(); k++) begin
      repeat (1 + rnd() % 4) tick();
      fork
        hm.xfer(8'(rnd()), r);
        if (k == txq.size() - 1) begin
          repeat (8) @(posedge sclk);
          tick();
          tx_valid = 1'b0;
        end
      join
      cmp8(r, txq[k]);
    end
    wait_lvl(1'b1, 200);
  endtask : dev_rx
  task automatic host_pkt(input int n);
    logic [7:0] b, r;
    hm.wake(1'b1);
    pulse();
    hm.wake(1'b0);
    for (int k = 0; k < n; k++) begin
      b = 8'(rnd());
      rxq.push_back(b);
      hm.xfer(b, r);
    end
    repeat (4) tick();
    rx_end = 1'b1;
    tick();
    rx_end = 1'b0;
    cmpn(rxq.size(), 0);
  endtask : host_pkt
  // ----------------------------------------
  // Local side drivers and monitors
  // ----------------------------------------
  always @(posedge clk) begin
    errs <= errs + int'(ack_err === 1'b1);
    tmos <= tmos + int'(tmo === 1'b1);
    if (rx_valid === 1'b1) begin
      if (rxq.size() == 0)
        cmpn(1, 0);
      else
        cmp8(rx_byte, rxq.pop_front());
    end
    if (tx_ready === 1'b1) begin
      #1;
      ti++;
      if (ti < txq.size()) begin
        tx_byte = txq[ti];
        tx_last = ti == txq.size() - 1;
      end
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) tick();
    host_pkt(3);
    load(3);
    rts(8'h88);
    dev_rx();
    load(2);
    rts(8'h55);
    rts(8'h88);
    dev_rx();
    cmpn(errs, 1);
    load(1);
    pulse();
    rts(8'h88);
    dev_rx();
    cmpn(tmos, 1);
    // Host misses the grant, gives up and asks again
    hm.wake(1'b1);
    pulse();
    repeat (100) tick();
    hm.wake(1'b0);
    tick();
    host_pkt(1);
    cmpn(tmos, 2);
    load(2);
    pulse();
    host_pkt(2);
    rts(8'h88);
    dev_rx();
    summarize();
  end
endmodule : test_handshake_link
